// ---- rtl/sfif_regs.vh ----
// Purpose: Named constants for the serial flash instruction framing block.
// Assumes: Included by its bare name from the design file.
// Notes: Definitions only; no logic lives here.
`ifndef SFIF_REGS_VH
`define SFIF_REGS_VH

// Opcodes recognised by the framing logic.
`define SFIF_OP_WR_ENABLE 8'h06
`define SFIF_OP_WR_DISABLE 8'h04
`define SFIF_OP_STAT_LO 8'h05
`define SFIF_OP_STAT_HI 8'h35
`define SFIF_OP_STAT_WRITE 8'h01
`define SFIF_OP_PAGE_PROG 8'h02
`define SFIF_OP_SECT_ERASE 8'h20
`define SFIF_OP_BLK_ERASE 8'hD8
`define SFIF_OP_CHIP_ERASE_A 8'hC7
`define SFIF_OP_CHIP_ERASE_B 8'h60
`define SFIF_OP_PART_SHORT 8'hAB
`define SFIF_OP_MAKER_PART 8'h90
`define SFIF_OP_PART_LONG 8'h9F

// Frame geometry.
`define SFIF_LAST_BIT 3'h7
`define SFIF_ADDR_BYTES 9'h003
`define SFIF_PROG_MIN_BYTES 9'h004
`define SFIF_SWR_MIN_BYTES 9'h001
`define SFIF_BYTE_CNT_MAX 9'h1FF

// Status word bit positions.
`define SFIF_STAT_BUSY 0
`define SFIF_STAT_WPL 1

`endif

// ---- rtl/sfif_frame.v ----
// Purpose: Instruction framing front end of a serial flash on an SPI link.
// Assumes: Select, clock and data arrive asynchronously and are oversampled by i_clock.
// Notes: The array, protection and status storage live in a core outside this block.
// Overview of operation
// - Select falling starts a new instruction frame.
// - First eight bits after select falls form the opcode.
// - Serial input sampled on rising clock edges, most significant bit first.
// - Frame is opcode alone or with address, data or dummy bytes.
// - Select rising ends the frame and triggers completion actions.
// - Read instructions may end after any clocked bit.
// - Write, program or erase ending mid-byte is abandoned without changes.
// - While busy, every opcode except status read 05h is ignored.
// - Fixed maker code; part code for ABh, 90h; long code for 9Fh.
// - Write permission latch set by enable, cleared by reset and writes.
// - Opcode 04h is write disable, clearing the permission latch.
// - 05h returns status bits 7..0, 35h returns bits 15..8.
`timescale 1ns/10ps
`default_nettype none
`include "sfif_regs.vh"

module sfif_frame #(
  parameter [7:0] MAKER_CODE = 8'h5A,     // Arbitrary value.
  parameter [15:0] PART_CODE = 16'h2C3D   // Arbitrary value.
) (
  // Clock and reset.
  input wire i_clock,
  input wire i_reset_n,
  // SPI pins from the host.
  input wire i_select_n,
  input wire i_serial_clock,
  input wire i_serial_in_line,
  // SPI data output, two signals for the shared pin.
  output wire o_serial_out,
  output wire o_serial_out_en,
  // Core status, same clock domain; bit 0 is busy.
  input wire [15:0] i_status_bits,
  // Completed command to the core.
  output wire o_cmd_strobe,
  output wire [7:0] o_cmd_code,
  output wire [23:0] o_cmd_addr,
  output wire o_cmd_abort,
  // Staged data bytes for program and status write.
  output wire o_data_strobe,
  output wire [7:0] o_data_byte,
  // Latch state.
  output wire o_write_permission_latch
);

  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_OPC = 5'h02;
  localparam [4:0] ST_ARG = 5'h04;
  localparam [4:0] ST_RESP = 5'h08;
  localparam [4:0] ST_IGN = 5'h10;

  // True for opcodes that alter the array or status and need byte alignment.
  function is_write_op;
    input [7:0] op;
    begin
      is_write_op = (op == `SFIF_OP_STAT_WRITE) || (op == `SFIF_OP_PAGE_PROG) ||
                    (op == `SFIF_OP_SECT_ERASE) || (op == `SFIF_OP_BLK_ERASE) ||
                    (op == `SFIF_OP_CHIP_ERASE_A) || (op == `SFIF_OP_CHIP_ERASE_B);
    end
  endfunction

  // True when the argument byte count suits a write-type opcode: a minimum for program and status write, an exact count otherwise.
  function args_ok;
    input [7:0] op;
    input [8:0] n;
    begin
      case (op)
        `SFIF_OP_STAT_WRITE: args_ok = (n >= `SFIF_SWR_MIN_BYTES);
        `SFIF_OP_PAGE_PROG: args_ok = (n >= `SFIF_PROG_MIN_BYTES);
        `SFIF_OP_SECT_ERASE: args_ok = (n == `SFIF_ADDR_BYTES);
        `SFIF_OP_BLK_ERASE: args_ok = (n == `SFIF_ADDR_BYTES);
        default: args_ok = (n == 9'h000);
      endcase
    end
  endfunction

  // Identification byte number idx for an id opcode.
  function [7:0] id_byte;
    input [7:0] op;
    input [8:0] idx;
    begin
      case (op)
        `SFIF_OP_PART_LONG: begin
          if (idx == 9'h000) id_byte = MAKER_CODE;
          else if (idx == 9'h001) id_byte = PART_CODE[15:8];
          else id_byte = PART_CODE[7:0];
        end
        `SFIF_OP_MAKER_PART: id_byte = idx[0] ? PART_CODE[7:0] : MAKER_CODE;
        default: id_byte = PART_CODE[7:0];
      endcase
    end
  endfunction

  reg sel_s1_ff, sel_s2_ff, sel_d_ff;
  reg sck_s1_ff, sck_s2_ff, sck_d_ff;
  reg din_s1_ff, din_s2_ff;
  reg [4:0] state_ff;
  reg [2:0] bit_cnt_ff;
  reg [6:0] shift_in_ff;
  reg [7:0] opcode_ff;
  reg [8:0] byte_cnt_ff;
  reg [8:0] resp_idx_ff;
  reg [23:0] addr_ff;
  reg [7:0] resp_ff;
  reg wpl_ff;
  reg sout_ff, sout_en_ff;
  reg cmd_strobe_ff, abort_ff, data_strobe_ff;
  reg [7:0] data_byte_ff;

  wire sel_fall = sel_d_ff & ~sel_s2_ff;
  wire sel_rise = ~sel_d_ff & sel_s2_ff;
  wire sck_rise = ~sck_d_ff & sck_s2_ff & ~sel_s2_ff;
  wire sck_fall = sck_d_ff & ~sck_s2_ff & ~sel_s2_ff;
  wire byte_done = sck_rise && (bit_cnt_ff == `SFIF_LAST_BIT);
  wire [7:0] new_byte = {shift_in_ff, din_s2_ff};
  wire busy = i_status_bits[`SFIF_STAT_BUSY];
  // Status word as seen by the host, with the latch merged in.
  wire [15:0] stat_word = {i_status_bits[15:2], wpl_ff, busy};

  // Two-stage synchronisers; the first stage feeds only the second.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_s1_ff <= 1'b1;
      sel_s2_ff <= 1'b1;
      sel_d_ff <= 1'b1;
      sck_s1_ff <= 1'b0;
      sck_s2_ff <= 1'b0;
      sck_d_ff <= 1'b0;
      din_s1_ff <= 1'b0;
      din_s2_ff <= 1'b0;
    end else begin
      sel_s1_ff <= i_select_n;
      sel_s2_ff <= sel_s1_ff;
      sel_d_ff <= sel_s2_ff;
      sck_s1_ff <= i_serial_clock;
      sck_s2_ff <= sck_s1_ff;
      sck_d_ff <= sck_s2_ff;
      din_s1_ff <= i_serial_in_line;
      din_s2_ff <= din_s1_ff;
    end
  end

  // Frame sequencer. Select edges take priority over clock edges, so a frame
  // that ends on the same sample as its last clock is closed, not extended.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_ff <= ST_IDLE;
      bit_cnt_ff <= 3'h0;
      shift_in_ff <= 7'h00;
      opcode_ff <= 8'h00;
      byte_cnt_ff <= 9'h000;
      resp_idx_ff <= 9'h000;
      addr_ff <= 24'h000000;
      resp_ff <= 8'h00;
      wpl_ff <= 1'b0;
      cmd_strobe_ff <= 1'b0;
      abort_ff <= 1'b0;
      data_strobe_ff <= 1'b0;
      data_byte_ff <= 8'h00;
    end else begin
      cmd_strobe_ff <= 1'b0;
      abort_ff <= 1'b0;
      data_strobe_ff <= 1'b0;
      if (sel_fall) begin
        state_ff <= ST_OPC;
        bit_cnt_ff <= 3'h0;
        byte_cnt_ff <= 9'h000;
        resp_idx_ff <= 9'h000;
      end else if (sel_rise) begin
        state_ff <= ST_IDLE;
        // Reads need no completion, so they end on any bit.
        if (state_ff == ST_ARG && is_write_op(opcode_ff)) begin
          if (bit_cnt_ff != 3'h0) begin
            abort_ff <= 1'b1;
          end else if (args_ok(opcode_ff, byte_cnt_ff) && wpl_ff) begin
            cmd_strobe_ff <= 1'b1;
            wpl_ff <= 1'b0;
          end
        end else if (state_ff == ST_ARG && bit_cnt_ff == 3'h0 && byte_cnt_ff == 9'h000) begin
          if (opcode_ff == `SFIF_OP_WR_ENABLE) begin
            wpl_ff <= 1'b1;
          end else if (opcode_ff == `SFIF_OP_WR_DISABLE) begin
            wpl_ff <= 1'b0;
          end
        end
      end else if (sck_rise && state_ff != ST_IDLE) begin
        bit_cnt_ff <= bit_cnt_ff + 3'h1;
        shift_in_ff <= new_byte[6:0];
        if (byte_done) begin
          case (state_ff)
            ST_OPC: begin
              opcode_ff <= new_byte;
              if (busy && new_byte != `SFIF_OP_STAT_LO) begin
                state_ff <= ST_IGN;
              end else begin
                case (new_byte)
                  `SFIF_OP_STAT_LO: begin
                    resp_ff <= stat_word[7:0];
                    state_ff <= ST_RESP;
                  end
                  `SFIF_OP_STAT_HI: begin
                    resp_ff <= stat_word[15:8];
                    state_ff <= ST_RESP;
                  end
                  `SFIF_OP_PART_LONG: begin
                    resp_ff <= id_byte(new_byte, 9'h000);
                    resp_idx_ff <= 9'h001;
                    state_ff <= ST_RESP;
                  end
                  `SFIF_OP_WR_ENABLE, `SFIF_OP_WR_DISABLE, `SFIF_OP_PART_SHORT,
                  `SFIF_OP_MAKER_PART, `SFIF_OP_STAT_WRITE, `SFIF_OP_PAGE_PROG,
                  `SFIF_OP_SECT_ERASE, `SFIF_OP_BLK_ERASE, `SFIF_OP_CHIP_ERASE_A,
                  `SFIF_OP_CHIP_ERASE_B: begin
                    state_ff <= ST_ARG;
                  end
                  default: begin
                    state_ff <= ST_IGN;
                  end
                endcase
              end
            end
            ST_ARG: begin
              if (byte_cnt_ff != `SFIF_BYTE_CNT_MAX) begin
                byte_cnt_ff <= byte_cnt_ff + 9'h001;
              end
              if (opcode_ff == `SFIF_OP_STAT_WRITE ||
                  (opcode_ff == `SFIF_OP_PAGE_PROG && byte_cnt_ff >= `SFIF_ADDR_BYTES)) begin
                data_strobe_ff <= 1'b1;
                data_byte_ff <= new_byte;
              end else if (byte_cnt_ff < `SFIF_ADDR_BYTES) begin
                addr_ff <= {addr_ff[15:0], new_byte};
                if (byte_cnt_ff == `SFIF_ADDR_BYTES - 9'h001 &&
                    (opcode_ff == `SFIF_OP_PART_SHORT || opcode_ff == `SFIF_OP_MAKER_PART)) begin
                  resp_ff <= id_byte(opcode_ff, 9'h000);
                  resp_idx_ff <= 9'h001;
                  state_ff <= ST_RESP;
                end
              end
            end
            ST_RESP: begin
              // Status reads repeat the live status; id reads walk their bytes.
              if (opcode_ff == `SFIF_OP_STAT_LO) begin
                resp_ff <= stat_word[7:0];
              end else if (opcode_ff == `SFIF_OP_STAT_HI) begin
                resp_ff <= stat_word[15:8];
              end else begin
                resp_ff <= id_byte(opcode_ff, resp_idx_ff);
                if (resp_idx_ff != `SFIF_BYTE_CNT_MAX) begin
                  resp_idx_ff <= resp_idx_ff + 9'h001;
                end
              end
            end
            default: begin
              state_ff <= state_ff;
            end
          endcase
        end
      end else if (sck_fall && state_ff == ST_RESP) begin
        resp_ff <= {resp_ff[6:0], 1'b0};
      end
    end
  end

  // Output pin driver; it changes two to three system clocks after the host's falling
  // edge, so the host gets less than a half period of setup before its rising-edge sample.
  always @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sout_ff <= 1'b0;
      sout_en_ff <= 1'b0;
    end else if (sel_s2_ff) begin
      sout_en_ff <= 1'b0;
    end else if (sck_fall && state_ff == ST_RESP) begin
      sout_ff <= resp_ff[7];
      sout_en_ff <= 1'b1;
    end
  end

  assign o_serial_out = sout_ff;
  assign o_serial_out_en = sout_en_ff;
  assign o_cmd_strobe = cmd_strobe_ff;
  assign o_cmd_code = opcode_ff;
  assign o_cmd_addr = addr_ff;
  assign o_cmd_abort = abort_ff;
  assign o_data_strobe = data_strobe_ff;
  assign o_data_byte = data_byte_ff;
  assign o_write_permission_latch = wpl_ff;

endmodule // sfif_frame

`default_nettype wire

// ---- dv/sfif_frame_props.sv ----
// Purpose: Port-level checker for the instruction framing block.
// Assumes: Host keeps select high at least 8 clocks between frames.
// Notes: Bound to every instance of the framing block.
`timescale 1ns/10ps
`default_nettype none
module sfif_frame_props (
  // Clock and reset.
  input wire logic i_clock,
  input wire logic i_reset_n,
  // Link pins.
  input wire logic i_select_n,
  input wire logic i_serial_clock,
  input wire logic i_serial_in_line,
  input wire logic o_serial_out,
  input wire logic o_serial_out_en,
  // Core side.
  input wire logic [15:0] i_status_bits,
  input wire logic o_cmd_strobe,
  input wire logic [7:0] o_cmd_code,
  input wire logic [23:0] o_cmd_addr,
  input wire logic o_cmd_abort,
  input wire logic o_data_strobe,
  input wire logic [7:0] o_data_byte,
  input wire logic o_write_permission_latch
);
  logic [6:0] bsy_cnt_ff;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n);
  // Busy age counter; a latch rise after a long busy spell means the enable was taken while busy.
  always_ff @(posedge i_clock or negedge i_reset_n) begin
    if (!i_reset_n) bsy_cnt_ff <= 7'h00;
    else if (!i_status_bits[0]) bsy_cnt_ff <= 7'h00;
    else if (bsy_cnt_ff != 7'h7F) bsy_cnt_ff <= bsy_cnt_ff + 7'h01;
  end
  property p_idle; i_select_n [*5] |-> !o_serial_out_en; endproperty
  a_idle: assert property (p_idle) else $error("data pin driven while idle");
  property p_strb_end; o_cmd_strobe |-> $past(i_select_n, 2); endproperty
  a_strb_end: assert property (p_strb_end) else $error("commit inside frame");
  property p_strb_wpl; o_cmd_strobe |-> !o_write_permission_latch; endproperty
  a_strb_wpl: assert property (p_strb_wpl) else $error("latch kept on commit");
  property p_strb_was; o_cmd_strobe |-> $past(o_write_permission_latch); endproperty
  a_strb_was: assert property (p_strb_was) else $error("commit without latch");
  property p_abort; o_cmd_abort |-> !o_cmd_strobe && $stable(o_write_permission_latch)
    ##1 !o_cmd_abort; endproperty
  a_abort: assert property (p_abort) else $error("abort changed state");
  property p_wpl_end; $changed(o_write_permission_latch) |-> $past(i_select_n, 2); endproperty
  a_wpl_end: assert property (p_wpl_end) else $error("latch moved mid frame");
  property p_busy; bsy_cnt_ff == 7'h7F |-> !$rose(o_write_permission_latch); endproperty
  a_busy: assert property (p_busy) else $error("enable taken while busy");
  property p_data; o_data_strobe |-> o_cmd_code == 8'h02 || o_cmd_code == 8'h01; endproperty
  a_data: assert property (p_data) else $error("data byte in wrong frame");
  c_cmd: cover property (o_cmd_strobe);
  c_abort: cover property (o_cmd_abort);
  c_data: cover property (o_data_strobe);
  c_read: cover property (o_serial_out_en);
endmodule // sfif_frame_props
bind sfif_frame sfif_frame_props u_sfif_frame_props (.*);
`default_nettype wire

// ---- dv/sfif_spi_host.sv ----
// Purpose: Behavioural host driving select, clock and data in mode 0.
// Assumes: Link clock period of 8 system clocks, 320 ns.
// Notes: Clock stands low outside frames; data line flips when released.
`timescale 1ns/10ps
`default_nettype none
module sfif_spi_host (
  // Pacing clock.
  input wire logic i_clock,
  // Pins toward the device.
  output logic o_select_n,
  output logic o_serial_clock,
  output logic o_serial_in_line,
  input wire logic i_serial_out
);
  initial begin
    o_select_n = 1'b1;
    o_serial_clock = 1'b0;
    o_serial_in_line = 1'b0;
  end
  // Frame edges; the long wait keeps the idle gap above what sync needs.
  task automatic sel(input logic v);
    @(negedge i_clock);
    o_select_n = v;
    if (v) o_serial_in_line = ~o_serial_in_line;
    repeat (8) @(negedge i_clock);
  endtask
  // Shift n bits MSB first, sampling the reply at each rising edge.
  task automatic xb(input logic [7:0] d, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int k = 0; k < n; k++) begin
      o_serial_in_line = d[7-k];
      repeat (4) @(negedge i_clock);
      o_serial_clock = 1'b1;
      r = {r[6:0], i_serial_out};
      repeat (4) @(negedge i_clock);
      o_serial_clock = 1'b0;
    end
  endtask
endmodule // sfif_spi_host
`default_nettype wire

// ---- dv/sfif_frame_tb_top.sv ----
// Purpose: Self-checking bench for the instruction framing block.
// Assumes: Host model paces the link; status word driven here.
// Notes: Read rows and write commit rows run from tables, other write paths by hand.
`timescale 1ns/10ps
`default_nettype none
module sfif_frame_tb_top;
  localparam logic [7:0] MK = 8'h5A; // Arbitrary value.
  localparam logic [15:0] PT = 16'hC3A9; // Arbitrary value.
  logic clock = 1'b0, reset_n = 1'b0, sn, sck, sdi, so, soe, cs, ab, ds, wpl;
  logic [15:0] st = 16'hA5C0;
  logic [7:0] code, db, rx[6], j;
  logic [23:0] addr;
  int n_mismatch = 0, total_checks = 0, n_cmd = 0, n_abt = 0, n_dat = 0, n_oe = 0, c0, c1;
  // Write-type frames that must commit once the latch is set.
  logic [47:0] w_fr[4] = '{48'h013C << 32, 48'hD80A0B0C << 16, 48'hC7 << 40, 48'h60 << 40};
  int w_nb[4] = '{2, 4, 1, 1};
  logic [7:0] r_op[5] = '{8'h05, 8'h35, 8'h9F, 8'hAB, 8'h90};
  int r_sk[5] = '{0, 0, 0, 3, 3};
  logic [15:0] r_ex[5] = '{16'hC0C0, 16'hA5A5, {MK, PT[15:8]}, {2{PT[7:0]}}, {MK, PT[7:0]}};
  always #20 clock = ~clock;
  sfif_frame #(.MAKER_CODE(MK), .PART_CODE(PT)) u_sfif_frame (.i_clock(clock),
    .i_reset_n(reset_n), .i_select_n(sn), .i_serial_clock(sck), .i_serial_in_line(sdi),
    .o_serial_out(so), .o_serial_out_en(soe), .i_status_bits(st), .o_cmd_strobe(cs),
    .o_cmd_code(code), .o_cmd_addr(addr), .o_cmd_abort(ab), .o_data_strobe(ds),
    .o_data_byte(db), .o_write_permission_latch(wpl));
  sfif_spi_host u_sfif_spi_host (.i_clock(clock), .o_select_n(sn), .o_serial_clock(sck),
    .o_serial_in_line(sdi), .i_serial_out(so));
  // Pulses are counted here so one-cycle strobes are never missed.
  always @(posedge clock) begin
    n_cmd += cs;
    n_abt += ab;
    n_dat += ds;
    n_oe += soe;
  end
  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One frame: nb whole bytes from the top of d, then tail extra bits.
  task automatic fr(input logic [47:0] d, input int nb, input int tail);
    u_sfif_spi_host.sel(1'b0);
    for (int i = 0; i < nb; i++) u_sfif_spi_host.xb(d[47-8*i -: 8], 8, rx[i]);
    if (tail > 0) u_sfif_spi_host.xb(8'hFF, tail, j);
    u_sfif_spi_host.sel(1'b1);
  endtask
  initial begin
    repeat (60000) @(posedge clock);
    n_mismatch++;
    summarize();
  end
  initial begin
    repeat (4) @(negedge clock);
    chk({wpl, soe, cs, ab, ds}, 24'h0);
    reset_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int r = 0; r < 5; r++) begin
      fr({r_op[r], 40'h0}, 3 + r_sk[r], 0);
      chk({rx[1+r_sk[r]], rx[2+r_sk[r]]}, r_ex[r]);
    end
    fr(48'h06 << 40, 1, 0);
    chk(wpl, 1);
    fr(48'h05 << 40, 1, 3);
    fr(48'h05 << 40, 2, 0);
    chk(rx[1], 8'hC2);
    c0 = n_cmd;
    fr(48'h20123456 << 16, 4, 0);
    chk(n_cmd - c0, 1);
    chk(code, 8'h20);
    chk(addr, 24'h123456);
    chk(wpl, 0);
    fr(48'h06 << 40, 1, 0);
    c0 = n_dat;
    c1 = n_cmd;
    fr(48'h02ABCDEF3C << 8, 5, 0);
    chk(n_dat - c0, 1);
    chk(db, 8'h3C);
    chk(addr, 24'hABCDEF);
    chk(n_cmd - c1, 1);
    fr(48'h06 << 40, 1, 0);
    c0 = n_cmd;
    c1 = n_abt;
    fr(48'h02ABCDEF << 16, 4, 4);
    chk(n_abt - c1, 1);
    chk(n_cmd - c0, 0);
    chk(wpl, 1);
    fr(48'h04 << 40, 1, 0);
    chk(wpl, 0);
    c0 = n_cmd;
    fr(48'h20123456 << 16, 4, 0);
    chk(n_cmd - c0, 0);
    st = 16'hA5C1;
    repeat (130) @(negedge clock);
    fr(48'h06 << 40, 1, 0);
    chk(wpl, 0);
    fr(48'h05 << 40, 2, 0);
    chk(rx[1], 8'hC1);
    st = 16'hA5C0;
    c0 = n_oe;
    fr(48'hE7FFFF << 24, 3, 0);
    fr(48'h06 << 40, 1, 0);
    chk(n_oe - c0, 0);
    chk(wpl, 1);
    for (int w = 0; w < 4; w++) begin
      fr(48'h06 << 40, 1, 0);
      c0 = n_cmd;
      fr(w_fr[w], w_nb[w], 0);
      chk(n_cmd - c0, 1);
      chk(code, w_fr[w][47:40]);
      chk(wpl, 0);
    end
    summarize();
  end
endmodule // sfif_frame_tb_top
`default_nettype wire
